// *** hdl/sag_top.v ***
`timescale 1ns/1ps
`include "sag_defs.vh"
// ====================================================
// segmented address generator: register set, segment pick, address out
module sag_top (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // register write port
    input wire wr_en,
    input wire [3:0] wr_idx,
    input wire wr_byte,
    input wire wr_high,
    input wire [15:0] wr_data,
    // register read port
    input wire [3:0] rd_idx,
    input wire rd_byte,
    input wire rd_high,
    output wire [15:0] rd_data,
    // address request
    input wire req_valid,
    input wire [2:0] ref_kind,
    input wire [2:0] addr_mode,
    input wire base_is_bp,
    input wire idx_is_dst,
    input wire indir_sel_base,
    input wire disp_is_byte,
    input wire [15:0] disp,
    input wire override_en,
    input wire [1:0] override_seg,
    // operand request
    input wire [1:0] op_src,
    input wire [3:0] op_reg,
    input wire op_byte,
    input wire op_high,
    input wire [15:0] op_imm,
    // results
    output reg addr_valid,
    output reg [19:0] phys_addr,
    output reg [15:0] eff_addr,
    output reg [1:0] seg_used,
    output reg [15:0] operand,
    output reg operand_valid
);
    // ================================================
    // architectural register storage
    reg [15:0] regs_reg [0:`SAG_NUM_REGS-1];
    wire [15:0] ea_w;
    wire uses_bp_w;
    wire [19:0] paddr_w;
    reg [1:0] seg_sel;
    reg [15:0] seg_val;
    reg [15:0] offset_sel;
    reg [15:0] operand_next;

    // byte lanes only exist on the first four general registers
    function [15:0] read_view;
        input [15:0] word;
        input [3:0] idx;
        input byte_m;
        input high;
        begin
            if (byte_m && idx < 4'h4) begin
                read_view = high ? {8'h00, word[15:8]} : {8'h00, word[7:0]};
            end else begin
                read_view = word;
            end
        end
    endfunction

    // ================================================
    // register file writes, byte-lane merge for split registers
    genvar gi;
    generate
        for (gi = 0; gi < `SAG_NUM_REGS; gi = gi + 1) begin : g_regs
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    regs_reg[gi] <= `SAG_RST_WORD;
                end else if (wr_en && wr_idx == gi) begin
                    if (wr_byte && gi < 4) begin
                        if (wr_high) begin
                            regs_reg[gi] <= {wr_data[7:0], regs_reg[gi][7:0]};
                        end else begin
                            regs_reg[gi] <= {regs_reg[gi][15:8], wr_data[7:0]};
                        end
                    end else begin
                        regs_reg[gi] <= wr_data;
                    end
                end
            end
        end
    endgenerate

    // read port is combinational; out of range indices read zero
    assign rd_data = (rd_idx < `SAG_NUM_REGS) ?
        read_view(regs_reg[rd_idx], rd_idx, rd_byte, rd_high) : 16'h0000;

    // ================================================
    // effective address
    sag_ea_calc u_ea (
        .mode(addr_mode),
        .idx_is_dst(idx_is_dst),
        .base_is_bp(base_is_bp),
        .disp_is_byte(disp_is_byte),
        .disp(disp),
        .base_b(regs_reg[`SAG_R_BASE]),
        .base_ptr(regs_reg[`SAG_R_BPTR]),
        .src_idx(regs_reg[`SAG_R_SRC]),
        .dst_idx(regs_reg[`SAG_R_DST]),
        .indir_sel_base(indir_sel_base),
        .ea(ea_w),
        .uses_bp(uses_bp_w)
    );

    // ================================================
    // segment choice and offset choice per kind of reference
    always @* begin
        offset_sel = ea_w;
        case (ref_kind)
            `SAG_REF_FETCH: begin
                seg_sel = `SAG_SEG_C;
                offset_sel = regs_reg[`SAG_R_IPTR];
            end
            `SAG_REF_IMM: begin
                seg_sel = `SAG_SEG_C;
                offset_sel = regs_reg[`SAG_R_IPTR];
            end
            `SAG_REF_STACK: begin
                seg_sel = `SAG_SEG_S;
                offset_sel = regs_reg[`SAG_R_STK];
            end
            `SAG_REF_STRDST: begin
                seg_sel = `SAG_SEG_E;
                offset_sel = regs_reg[`SAG_R_DST];
            end
            default: begin
                // base pointer as base pulls data onto the stack segment
                seg_sel = uses_bp_w ? `SAG_SEG_S : `SAG_SEG_D;
            end
        endcase
        // prefetch and stack pushes are not operand accesses: no override
        if (override_en && (ref_kind == `SAG_REF_DATA)) begin
            seg_sel = override_seg;
        end
        case (seg_sel)
            `SAG_SEG_E: seg_val = regs_reg[`SAG_R_ESEG];
            `SAG_SEG_C: seg_val = regs_reg[`SAG_R_CSEG];
            `SAG_SEG_S: seg_val = regs_reg[`SAG_R_SSEG];
            default: seg_val = regs_reg[`SAG_R_DSEG];
        endcase
    end

    sag_paddr u_pa (
        .seg_base(seg_val),
        .offset(offset_sel),
        .paddr(paddr_w)
    );

    // ================================================
    // operand source: register or immediate
    always @* begin
        case (op_src)
            `SAG_OP_REG: operand_next = read_view(regs_reg[op_reg[2:0]],
                {1'b0, op_reg[2:0]}, op_byte, op_high);
            `SAG_OP_IMM: operand_next = op_byte ?
                {8'h00, op_imm[7:0]} : op_imm;
            default: operand_next = 16'h0000;
        endcase
    end

    // ================================================
    // registered results, one cycle after the request
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_valid <= 1'b0;
            phys_addr <= 20'h00000;
            eff_addr <= 16'h0000;
            seg_used <= 2'h0;
            operand <= 16'h0000;
            operand_valid <= 1'b0;
        end else begin
            addr_valid <= req_valid && (op_src == `SAG_OP_MEM);
            operand_valid <= req_valid && (op_src != `SAG_OP_MEM);
            if (req_valid) begin
                phys_addr <= paddr_w;
                eff_addr <= offset_sel;
                seg_used <= seg_sel;
                operand <= operand_next;
            end
        end
    end
endmodule // sag_top

// *** hdl/sag_defs.vh ***
// Notes on behaviour
// - fourteen 16-bit registers: eight general, four segment, pointer, state word
// - first four general registers read and write as words or byte halves
// - a segment spans at most 64K bytes via a 16-bit offset
// - physical address is segment base shifted left four plus offset
// - prefetch and immediate fetch use the code segment
// - stack push/pop and base-pointer-based references use the stack segment
// - string references indexed by destination index use the extra segment
// - all other data references use the data segment
// - a segment override prefix replaces the implied segment of data references only
// - offset is any sum of displacement, one base, one index
// - offset sum truncated to 16 bits, carry dropped
// - byte displacement is sign extended to 16 bits
// - register operand from general registers, immediate from the instruction
// - direct mode offset is the displacement alone
// - register indirect offset is one of index or base registers
// - based mode adds displacement to base or base pointer
// - indexed mode adds displacement to source or destination index
// - based indexed mode sums base and index, no displacement
// - based indexed with displacement sums base, index and displacement
`ifndef SAG_DEFS_VH
`define SAG_DEFS_VH
// ====================================================
// register file indices (word view)
`define SAG_R_ACC 4'h0
`define SAG_R_CNT 4'h1
`define SAG_R_DAT 4'h2
`define SAG_R_BASE 4'h3
`define SAG_R_STK 4'h4
`define SAG_R_BPTR 4'h5
`define SAG_R_SRC 4'h6
`define SAG_R_DST 4'h7
`define SAG_R_CSEG 4'h8
`define SAG_R_DSEG 4'h9
`define SAG_R_ESEG 4'ha
`define SAG_R_SSEG 4'hb
`define SAG_R_IPTR 4'hc
`define SAG_R_STATE 4'hd
`define SAG_NUM_REGS 14
// ====================================================
// segment codes
`define SAG_SEG_E 2'h0
`define SAG_SEG_C 2'h1
`define SAG_SEG_S 2'h2
`define SAG_SEG_D 2'h3
// ====================================================
// reference kinds
`define SAG_REF_FETCH 3'h0
`define SAG_REF_IMM 3'h1
`define SAG_REF_STACK 3'h2
`define SAG_REF_STRDST 3'h3
`define SAG_REF_DATA 3'h4
// ====================================================
// memory addressing modes
`define SAG_AM_DIRECT 3'h0
`define SAG_AM_INDIR 3'h1
`define SAG_AM_BASED 3'h2
`define SAG_AM_INDEXED 3'h3
`define SAG_AM_BI 3'h4
`define SAG_AM_BID 3'h5
// ====================================================
// operand source
`define SAG_OP_REG 2'h0
`define SAG_OP_IMM 2'h1
`define SAG_OP_MEM 2'h2
// ====================================================
// widths and reset values
`define SAG_WORD_W 16
`define SAG_PADDR_W 20
`define SAG_SEG_SHIFT 4
`define SAG_RST_WORD 16'h0000
`endif

// *** hdl/sag_ea_calc.v ***
`timescale 1ns/1ps
`include "sag_defs.vh"
// ====================================================
// effective address adder
module sag_ea_calc (
    // mode and operands
    input wire [2:0] mode,
    input wire idx_is_dst,
    input wire base_is_bp,
    input wire disp_is_byte,
    input wire [15:0] disp,
    input wire [15:0] base_b,
    input wire [15:0] base_ptr,
    input wire [15:0] src_idx,
    input wire [15:0] dst_idx,
    input wire indir_sel_base,
    // result
    output reg [15:0] ea,
    output reg uses_bp
);
    reg [15:0] disp_ext;
    reg [15:0] base_val;
    reg [15:0] idx_val;
    reg [16:0] sum_full;
    // sum of chosen elements, carry thrown away
    always @* begin
        disp_ext = disp_is_byte ? {{8{disp[7]}}, disp[7:0]} : disp;
        base_val = base_is_bp ? base_ptr : base_b;
        idx_val = idx_is_dst ? dst_idx : src_idx;
        uses_bp = 1'b0;
        sum_full = 17'h00000;
        case (mode)
            `SAG_AM_DIRECT: sum_full = {1'b0, disp_ext};
            `SAG_AM_INDIR: begin
                sum_full = {1'b0, indir_sel_base ? base_val : idx_val};
                uses_bp = indir_sel_base & base_is_bp;
            end
            `SAG_AM_BASED: begin
                sum_full = {1'b0, base_val} + {1'b0, disp_ext};
                uses_bp = base_is_bp;
            end
            `SAG_AM_INDEXED: sum_full = {1'b0, idx_val} + {1'b0, disp_ext};
            `SAG_AM_BI: begin
                sum_full = {1'b0, base_val} + {1'b0, idx_val};
                uses_bp = base_is_bp;
            end
            `SAG_AM_BID: begin
                sum_full = {1'b0, base_val} + {1'b0, idx_val} + {1'b0, disp_ext};
                uses_bp = base_is_bp;
            end
            default: sum_full = {1'b0, disp_ext};
        endcase
        ea = sum_full[15:0];
    end
endmodule // sag_ea_calc

// *** hdl/sag_paddr.v ***
`timescale 1ns/1ps
`include "sag_defs.vh"
// ====================================================
// segment-relative to physical address
module sag_paddr (
    // inputs
    input wire [15:0] seg_base,
    input wire [15:0] offset,
    // result
    output wire [19:0] paddr
);
    wire [20:0] full_sum;
    // shifted base plus offset; top carry dropped so the map wraps
    assign full_sum = {1'b0, seg_base, 4'h0} + {5'h00, offset};
    assign paddr = full_sum[19:0];
endmodule // sag_paddr

// *** tb/sag_top_assertions.sv ***
`timescale 1ns/1ps
`include "sag_defs.vh"
// ====================================================
// port checker for the segmented address generator
module sag_chk (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // request side
    input wire req_valid,
    input wire [2:0] ref_kind,
    input wire [2:0] addr_mode,
    input wire disp_is_byte,
    input wire [15:0] disp,
    input wire override_en,
    input wire [1:0] override_seg,
    input wire [1:0] op_src,
    input wire op_byte,
    input wire [15:0] op_imm,
    // results
    input wire addr_valid,
    input wire [19:0] phys_addr,
    input wire [15:0] eff_addr,
    input wire [1:0] seg_used,
    input wire [15:0] operand,
    input wire operand_valid
);
    // request decode; only the low byte matters for a byte displacement
    wire mem_req = req_valid && op_src == `SAG_OP_MEM;
    wire [15:0] disp_x = disp_is_byte ? {{8{disp[7]}}, disp[7:0]} : disp;
    wire data_req = mem_req && ref_kind == `SAG_REF_DATA;
    wire dir_data = data_req && addr_mode == `SAG_AM_DIRECT;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_addr_pulse: assert property (mem_req |=> addr_valid)
        else $error("no address pulse after request");
    chk_no_spurious: assert property
        (!req_valid |=> !addr_valid && !operand_valid)
        else $error("valid without request");
    chk_fetch_seg: assert property
        (mem_req && ref_kind <= `SAG_REF_IMM |=> seg_used == `SAG_SEG_C)
        else $error("fetch not in code segment");
    chk_stack_seg: assert property
        (mem_req && ref_kind == `SAG_REF_STACK |=> seg_used == `SAG_SEG_S)
        else $error("stack not in stack segment");
    chk_strdst_seg: assert property
        (mem_req && ref_kind == `SAG_REF_STRDST |=> seg_used == `SAG_SEG_E)
        else $error("string dest not in extra segment");
    chk_data_seg: assert property
        (dir_data && !override_en |=> seg_used == `SAG_SEG_D)
        else $error("direct data not in data segment");
    chk_override_seg: assert property
        (data_req && override_en |=> seg_used == $past(override_seg))
        else $error("override segment ignored");
    chk_direct_ea: assert property
        (dir_data |=> eff_addr == $past(disp_x))
        else $error("direct offset wrong");
    chk_low_nibble: assert property
        (addr_valid |-> phys_addr[3:0] == eff_addr[3:0])
        else $error("physical low nibble differs from offset");
    chk_imm_operand: assert property
        (req_valid && op_src == `SAG_OP_IMM && !op_byte
            |=> operand_valid && !addr_valid && operand == $past(op_imm))
        else $error("immediate operand wrong");

    cover property (data_req && override_en);
    cover property (dir_data && disp_is_byte);
    cover property (operand_valid);
endmodule // sag_chk

bind sag_top sag_chk u_chk (.*);

// *** tb/tb_sag_top.sv ***
`timescale 1ns/1ps
`include "sag_defs.vh"
// ====================================================
// self-checking bench for the segmented address generator
module tb_sag_top;
    typedef struct packed {
        logic [2:0] rk, am;
        logic bp, dx, sb, by;
        logic [15:0] d;
        logic ov;
        logic [1:0] os;
        logic [15:0] ea;
        logic [1:0] sg;
    } sag_row_t;
    reg sys_clk = 0, rst_n = 0, wr_en = 0, wr_byte = 0, wr_high = 0;
    reg rd_byte = 0, rd_high = 0, req_valid = 0, base_is_bp = 0;
    reg idx_is_dst = 0, indir_sel_base = 0, disp_is_byte = 0;
    reg override_en = 0, op_byte = 0, op_high = 0;
    reg [3:0] wr_idx = 0, rd_idx = 0, op_reg = 0;
    reg [15:0] wr_data = 0, disp = 0, op_imm = 0;
    reg [2:0] ref_kind = 0, addr_mode = 0;
    reg [1:0] override_seg = 0, op_src = 0;
    wire [15:0] rd_data, eff_addr, operand;
    wire [19:0] phys_addr;
    wire [1:0] seg_used;
    wire addr_valid, operand_valid;
    integer mismatches = 0, n_checks = 0, cyc = 0, i;
    reg [15:0] segv [0:3];
    sag_row_t rows [0:14];
    sag_row_t t;

    sag_top u_dut (.*);

    // clock and hang guard; about a hundred cycles are expected
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            mismatches = mismatches + 1;
            close_out;
        end
    end

    // ====================================================
    // shared tasks
    task chk(input string nm, input logic [19:0] e, g);
        n_checks = n_checks + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task wr(input [3:0] ix, input by, hi, input [15:0] d);
        @(posedge sys_clk);
        {wr_en, wr_idx, wr_byte, wr_high, wr_data} <= {1'b1, ix, by, hi, d};
        @(posedge sys_clk);
        wr_en <= 0;
    endtask
    task rd(input [3:0] ix, input by, hi, input [15:0] e);
        @(posedge sys_clk);
        {rd_idx, rd_byte, rd_high} <= {ix, by, hi};
        #1;
        chk("rd_data", e, rd_data);
    endtask
    task req(input sag_row_t r);
        @(posedge sys_clk);
        {ref_kind, addr_mode, base_is_bp} <= {r.rk, r.am, r.bp};
        {idx_is_dst, indir_sel_base, disp_is_byte} <= {r.dx, r.sb, r.by};
        {disp, override_en, override_seg} <= {r.d, r.ov, r.os};
        {req_valid, op_src} <= {1'b1, `SAG_OP_MEM};
    endtask
    // expected address built from the bench's own segment table
    task exp_row(input sag_row_t r);
        reg [19:0] pa;
        pa = {segv[r.sg], 4'h0} + {4'h0, r.ea};
        #1;
        chk("addr_valid", 1, addr_valid);
        chk("eff_addr", r.ea, eff_addr);
        chk("seg_used", r.sg, seg_used);
        chk("phys_addr", pa, phys_addr);
    endtask
    task opr(input [1:0] s, input [3:0] rg, input by, hi, input [15:0] im, e);
        @(posedge sys_clk);
        {op_src, op_reg, op_byte, op_high, op_imm} <= {s, rg, by, hi, im};
        req_valid <= 1;
        @(posedge sys_clk);
        req_valid <= 0;
        #1;
        chk("operand_valid", 1, operand_valid);
        chk("operand", e, operand);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ====================================================
    // main sequence
    initial begin
        segv[0] = 16'h3000;
        segv[1] = 16'h1000;
        segv[2] = 16'hffff;
        segv[3] = 16'h2000;
        rows[0] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 16'h0050, 1};
        rows[1] = '{1, 0, 0, 0, 0, 0, 0, 0, 0, 16'h0050, 1};
        rows[2] = '{2, 0, 0, 0, 0, 0, 0, 0, 0, 16'h0400, 2};
        rows[3] = '{3, 0, 0, 0, 0, 0, 0, 0, 0, 16'h0020, 0};
        rows[4] = '{4, 0, 0, 0, 0, 0, 16'h1234, 0, 0, 16'h1234, 3};
        rows[5] = '{4, 0, 0, 0, 0, 1, 16'h1280, 0, 0, 16'hff80, 3};
        rows[6] = '{4, 1, 0, 0, 1, 0, 0, 0, 0, 16'h0100, 3};
        rows[7] = '{4, 1, 1, 0, 1, 0, 0, 0, 0, 16'hfff0, 2};
        rows[8] = '{4, 1, 0, 1, 0, 0, 0, 0, 0, 16'h0020, 3};
        rows[9] = '{4, 2, 0, 0, 0, 0, 16'h0010, 0, 0, 16'h0110, 3};
        rows[10] = '{4, 3, 0, 0, 0, 1, 16'h00ff, 0, 0, 16'h000f, 3};
        rows[11] = '{4, 4, 0, 1, 0, 0, 16'h7777, 0, 0, 16'h0120, 3};
        rows[12] = '{4, 5, 1, 0, 0, 0, 16'h0030, 0, 0, 16'h0030, 2};
        rows[13] = '{4, 0, 0, 0, 0, 0, 16'h1234, 1, 0, 16'h1234, 0};
        rows[14] = '{0, 0, 0, 0, 0, 0, 0, 1, 3, 16'h0050, 1};
        repeat (20) @(posedge sys_clk);
        rst_n <= 1;
        rd(`SAG_R_DSEG, 0, 0, 16'h0000);
        $display("test reset done");
        // load pointers and segments; stack segment near top to force wraps
        wr(`SAG_R_CSEG, 0, 0, 16'h1000);
        wr(`SAG_R_DSEG, 0, 0, 16'h2000);
        wr(`SAG_R_ESEG, 0, 0, 16'h3000);
        wr(`SAG_R_SSEG, 0, 0, 16'hffff);
        wr(`SAG_R_BASE, 0, 0, 16'h0100);
        wr(`SAG_R_BPTR, 0, 0, 16'hfff0);
        wr(`SAG_R_SRC, 0, 0, 16'h0010);
        wr(`SAG_R_DST, 0, 0, 16'h0020);
        wr(`SAG_R_STK, 0, 0, 16'h0400);
        wr(`SAG_R_IPTR, 0, 0, 16'h0050);
        for (i = 0; i < 15; i = i + 1) begin
            req(rows[i]);
            @(posedge sys_clk);
            req_valid <= 0;
            exp_row(rows[i]);
        end
        $display("test rows done");
        // back to back, with a base write landing beside the first request
        t = rows[6];
        req(t);
        {wr_en, wr_idx, wr_data} <= {1'b1, `SAG_R_BASE, 16'h0200};
        req(t);
        wr_en <= 0;
        exp_row(t);
        t.ea = 16'h0200;
        @(posedge sys_clk);
        req_valid <= 0;
        exp_row(t);
        $display("test back to back done");
        wr(0, 0, 0, 16'h1234);
        wr(0, 1, 1, 16'h00ab);
        rd(0, 0, 0, 16'hab34);
        rd(0, 1, 0, 16'h0034);
        wr(4, 1, 1, 16'h5678);
        rd(4, 0, 0, 16'h5678);
        wr(`SAG_R_STATE, 0, 0, 16'hbeef);
        rd(`SAG_R_STATE, 0, 0, 16'hbeef);
        rd(4'he, 0, 0, 16'h0000);
        $display("test registers done");
        opr(`SAG_OP_REG, `SAG_R_BASE, 1, 1, 16'h0000, 16'h0002);
        opr(`SAG_OP_REG, `SAG_R_ACC, 0, 0, 16'h0000, 16'hab34);
        opr(`SAG_OP_IMM, 0, 0, 0, 16'hc3d2, 16'hc3d2);
        opr(`SAG_OP_IMM, 0, 1, 0, 16'hc3d2, 16'h00d2);
        $display("test operands done");
        // reset in mid-run clears registers and results
        @(posedge sys_clk);
        rst_n <= 0;
        rd(`SAG_R_BASE, 0, 0, 16'h0000);
        chk("phys_addr", 0, phys_addr);
        chk("addr_valid", 0, addr_valid);
        @(posedge sys_clk);
        rst_n <= 1;
        // first request right after release sees all-zero segments
        segv[3] = 16'h0000;
        req(rows[4]);
        @(posedge sys_clk);
        req_valid <= 0;
        exp_row(rows[4]);
        $display("test mid reset done");
        close_out;
    end
endmodule // tb_sag_top
